// ===== logic/remc_pkg.sv
package remc_pkg;
   // register byte offsets
   localparam logic [11:0] REMC_OFF_MSW = 12'h000;
   localparam logic [11:0] REMC_OFF_SRA = 12'h004;
   localparam logic [11:0] REMC_OFF_SRS = 12'h008;
   localparam logic [11:0] REMC_OFF_STS = 12'h00C;
   // machine_state_word fields, lsb-0 index (big-endian bit n sits at 31-n)
   localparam int REMC_B_POW = 18;
   localparam int REMC_B_ILE = 16;
   localparam int REMC_B_EE = 15;
   localparam int REMC_B_PR = 14;
   localparam int REMC_B_FP = 13;
   localparam int REMC_B_ME = 12;
   localparam int REMC_B_FE0 = 11;
   localparam int REMC_B_SE = 10;
   localparam int REMC_B_BE = 9;
   localparam int REMC_B_FE1 = 8;
   localparam int REMC_B_IP = 6;
   localparam int REMC_B_IR = 5;
   localparam int REMC_B_DR = 4;
   localparam int REMC_B_RI = 1;
   localparam int REMC_B_LE = 0;
   localparam logic [31:0] REMC_MSW_WMASK = 32'h0005_FF73;
   localparam logic [31:0] REMC_SRS_SAVE = 32'h0000_FF73;
   localparam logic [31:0] REMC_MSW_KEEP = 32'h0001_1040;
   localparam logic [31:0] REMC_MSW_RST = 32'h0000_0040;
   localparam logic [31:0] REMC_ZERO = 32'h0000_0000;
   // vectors
   localparam logic [31:0] REMC_BASE_LO = 32'h0000_0000;
   localparam logic [31:0] REMC_BASE_HI = 32'hFFF0_0000;
   localparam logic [31:0] REMC_VEC_RST = 32'h0000_0100;
   localparam logic [31:0] REMC_VEC_MC = 32'h0000_0200;
   // status register fields
   localparam int REMC_S_POR = 0;
   localparam int REMC_S_SOFT = 1;
   localparam int REMC_S_CSTOP = 2;
   localparam int REMC_S_LASTMC = 3;
   localparam int REMC_S_RECOV = 4;

   typedef enum logic {
      REMC_RUN = 1'b0,
      REMC_CSTOP = 1'b1
   } remc_state_t;

   // events that an exception entry would throw away
   typedef struct packed {
      logic ext_irq;
      logic dec_irq;
      logic dstore_err;
      logic fp_prog;
   } remc_loss_t;
endpackage

// ===== logic/remc_top.sv
`timescale 1ns/1ps
`default_nettype none
module remc_top
   import remc_pkg::*;
(
   input wire logic pclk, // apb clock, 10 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic sys_reset_pin, // system reset request, async level
   input wire logic bus_err_pin, // memory controller bus error, async level
   input wire logic nonexist_addr, // core: access to nonexistent address
   input wire logic [31:0] next_pc, // core: next instruction address
   input wire logic [31:0] exec_pc, // core: instruction executing now
   input wire logic ctx_sync_ok, // core: entry can be context-synchronizing
   input wire remc_loss_t loss, // core: pending events lost by entry
   output logic fetch_redirect, // pulse: fetch from fetch_vector
   output logic [31:0] fetch_vector, // handler entry address
   output logic sync_full, // pulse: synchronize earlier and later
   output logic sync_next, // pulse: synchronize later only
   output logic instr_exc_squash, // pulse: drop issuing instruction exceptions
   output logic halt, // stop instruction processing
   output logic checkstop // checkstop status
);

   function automatic logic [31:0] vec_addr(input logic ip, input logic [31:0] off);
      vec_addr = (ip ? REMC_BASE_HI : REMC_BASE_LO) | off;
   endfunction

   function automatic logic [31:0] save_state(input logic [31:0] msw, input logic recov);
      logic [31:0] s;
      s = msw & REMC_SRS_SAVE;
      s[REMC_B_RI] = recov & msw[REMC_B_RI];
      save_state = s;
   endfunction

   function automatic logic [31:0] entry_msw(input logic [31:0] msw, input logic is_mc);
      logic [31:0] m;
      m = msw & REMC_MSW_KEEP;
      m[REMC_B_LE] = msw[REMC_B_ILE];
      if (is_mc) begin
         m[REMC_B_ME] = 1'b0;
      end
      entry_msw = m;
   endfunction

   // three-stage synchronisers; a change counts once stages two and three agree
   logic [2:0] rst_sync_q;
   logic [2:0] berr_sync_q;
   logic rst_lvl_q;
   logic berr_lvl_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_sync_q <= 3'b000;
      end else begin
         rst_sync_q <= {rst_sync_q[1:0], sys_reset_pin};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         berr_sync_q <= 3'b000;
      end else begin
         berr_sync_q <= {berr_sync_q[1:0], bus_err_pin};
      end
   end

   wire logic rst_agree = (rst_sync_q[1] == rst_sync_q[2]);
   wire logic berr_agree = (berr_sync_q[1] == berr_sync_q[2]);
   wire logic rst_rise = rst_agree & rst_sync_q[2] & ~rst_lvl_q;
   wire logic berr_rise = berr_agree & berr_sync_q[2] & ~berr_lvl_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_lvl_q <= 1'b0;
      end else if (rst_agree) begin
         rst_lvl_q <= rst_sync_q[2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         berr_lvl_q <= 1'b0;
      end else if (berr_agree) begin
         berr_lvl_q <= berr_sync_q[2];
      end
   end

   // architectural registers and control state
   logic [31:0] msw_q;
   logic [31:0] sra_q;
   logic [31:0] srs_q;
   logic por_seen_q;
   logic soft_seen_q;
   logic cstop_seen_q;
   logic last_mc_q;
   logic last_recov_q;
   logic [4:0] sts_view;
   logic mc_pend_q;
   logic pend_bus_q;
   remc_state_t state_q;

   // exception selection
   logic any_loss;
   logic mc_now;
   logic take_rst;
   logic take_mc;
   logic enter_cs;
   logic rst_recov;
   logic mc_recov;

   always_comb begin
      any_loss = |loss;
      mc_now = mc_pend_q | berr_rise | nonexist_addr;
      take_rst = rst_rise;
      take_mc = ~take_rst & mc_now & (state_q == REMC_RUN) & msw_q[REMC_B_ME];
      enter_cs = ~take_rst & mc_now & (state_q == REMC_RUN) & ~msw_q[REMC_B_ME];
      rst_recov = ~any_loss;
      mc_recov = ctx_sync_ok & ~any_loss;
   end

   // a machine check held off by a reset waits here and is taken right after
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc_pend_q <= 1'b0;
      end else if (take_rst & mc_now) begin
         mc_pend_q <= 1'b1;
      end else if (take_mc | enter_cs | (state_q == REMC_CSTOP)) begin
         mc_pend_q <= 1'b0;
      end
   end

   // remembers whether the held-off check came from a bus error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_bus_q <= 1'b0;
      end else if (take_rst & mc_now) begin
         pend_bus_q <= berr_rise | pend_bus_q;
      end else if (take_mc | enter_cs | (state_q == REMC_CSTOP)) begin
         pend_bus_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= REMC_RUN;
      end else if (take_rst) begin
         state_q <= REMC_RUN;
      end else if (enter_cs) begin
         state_q <= REMC_CSTOP;
      end
   end

   // apb slave: zero wait states, answer registered in the setup cycle
   logic apb_setup;
   logic apb_wr;
   logic hit;
   logic [31:0] rd_mux;

   always_comb begin
      apb_setup = psel & ~penable;
      apb_wr = psel & penable & pwrite & pready;
      hit = (paddr == REMC_OFF_MSW) | (paddr == REMC_OFF_SRA) |
            (paddr == REMC_OFF_SRS) | (paddr == REMC_OFF_STS);
      unique case (paddr)
         REMC_OFF_MSW: rd_mux = msw_q & REMC_MSW_WMASK;
         REMC_OFF_SRA: rd_mux = sra_q;
         REMC_OFF_SRS: rd_mux = srs_q;
         REMC_OFF_STS: rd_mux = {27'h000_0000, sts_view};
         default: rd_mux = REMC_ZERO;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= apb_setup;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= apb_setup & ~hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= REMC_ZERO;
      end else if (apb_setup) begin
         prdata <= rd_mux;
      end
   end

   // msw, sra and srs writes are frozen in checkstop so the stopped state can be inspected; status clears still go through
   wire logic sw_ok = apb_wr & (state_q == REMC_RUN) & ~take_rst;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msw_q <= REMC_MSW_RST;
      end else if (take_rst) begin
         msw_q <= entry_msw(msw_q, 1'b0);
      end else if (take_mc) begin
         msw_q <= entry_msw(msw_q, 1'b1);
      end else if (sw_ok & (paddr == REMC_OFF_MSW)) begin
         msw_q <= pwdata & REMC_MSW_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sra_q <= REMC_ZERO;
      end else if (take_rst) begin
         sra_q <= next_pc;
      end else if (take_mc) begin
         sra_q <= exec_pc;
      end else if (sw_ok & (paddr == REMC_OFF_SRA)) begin
         sra_q <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         srs_q <= REMC_ZERO;
      end else if (take_rst) begin
         srs_q <= save_state(msw_q, rst_recov);
      end else if (take_mc) begin
         srs_q <= save_state(msw_q, mc_recov);
      end else if (sw_ok & (paddr == REMC_OFF_SRS)) begin
         srs_q <= pwdata;
      end
   end

   // status: write one to clear the two reset flags; a new event beats the clear
   wire logic sts_wr = apb_wr & (paddr == REMC_OFF_STS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_seen_q <= 1'b1;
      end else if (sts_wr & pwdata[REMC_S_POR]) begin
         por_seen_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_seen_q <= 1'b0;
      end else if (take_rst) begin
         soft_seen_q <= 1'b1;
      end else if (sts_wr & pwdata[REMC_S_SOFT]) begin
         soft_seen_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cstop_seen_q <= 1'b0;
      end else if (take_rst) begin
         cstop_seen_q <= 1'b0;
      end else if (enter_cs) begin
         cstop_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_mc_q <= 1'b0;
         last_recov_q <= 1'b0;
      end else if (take_rst | take_mc) begin
         last_mc_q <= take_mc;
         last_recov_q <= take_mc ? mc_recov : rst_recov;
      end
   end

   always_comb begin
      sts_view = '0;
      sts_view[REMC_S_POR] = por_seen_q;
      sts_view[REMC_S_SOFT] = soft_seen_q;
      sts_view[REMC_S_CSTOP] = cstop_seen_q;
      sts_view[REMC_S_LASTMC] = last_mc_q;
      sts_view[REMC_S_RECOV] = last_recov_q;
   end

   // core-facing outputs, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_redirect <= 1'b0;
      end else begin
         fetch_redirect <= take_rst | take_mc;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_vector <= REMC_ZERO;
      end else if (take_rst) begin
         fetch_vector <= vec_addr(msw_q[REMC_B_IP], REMC_VEC_RST);
      end else if (take_mc) begin
         fetch_vector <= vec_addr(msw_q[REMC_B_IP], REMC_VEC_MC);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_full <= 1'b0;
         sync_next <= 1'b0;
      end else begin
         sync_full <= (take_rst & rst_recov) | (take_mc & mc_recov);
         sync_next <= (take_rst & ~rst_recov) | (take_mc & ~mc_recov);
      end
   end

   // a check from a nonexistent address has no issuing bus operation to beat
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_exc_squash <= 1'b0;
      end else begin
         instr_exc_squash <= take_mc & (berr_rise | pend_bus_q);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt <= 1'b0;
      end else if (take_rst) begin
         halt <= 1'b0;
      end else if (enter_cs) begin
         halt <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         checkstop <= 1'b0;
      end else if (take_rst) begin
         checkstop <= 1'b0;
      end else if (enter_cs) begin
         checkstop <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// ===== bench/remc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module remc_assertions
   import remc_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // select
   input wire logic penable, // access phase
   input wire logic pwrite, // direction
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire logic [31:0] prdata, // read data
   input wire logic sys_reset_pin, // reset line
   input wire logic fetch_redirect, // redirect pulse
   input wire logic [31:0] fetch_vector, // handler address
   input wire logic sync_full, // full sync
   input wire logic sync_next, // later-only sync
   input wire logic instr_exc_squash, // squash pulse
   input wire logic halt, // halted
   input wire logic checkstop // stopped
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   vec_form_a: assert property (fetch_redirect |->
      fetch_vector[31:20] inside {12'h000, 12'hFFF} && fetch_vector[19:0] inside {20'h0_0100, 20'h0_0200})
      else $error("handler address outside the two vectors");
   sync_kind_a: assert property (fetch_redirect |-> sync_full != sync_next)
      else $error("entry without exactly one sync kind");
   sync_tied_a: assert property ((sync_full || sync_next) |-> fetch_redirect)
      else $error("sync pulse without redirect");
   squash_mc_a: assert property (instr_exc_squash |->
      fetch_redirect && fetch_vector[19:0] == 20'h0_0200) else $error("squash outside machine check");
   stop_quiet_a: assert property (checkstop |-> !fetch_redirect && halt)
      else $error("activity while stopped");
   stop_hold_a: assert property (checkstop && !sys_reset_pin |=> checkstop)
      else $error("checkstop left without system reset");
   rst_resp_a: assert property ($rose(sys_reset_pin) |-> ##[2:6] fetch_redirect)
      else $error("system reset not taken");
   ready_one_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not a single access cycle");
   err_read_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   cover property (fetch_redirect && fetch_vector[19:0] == 20'h0_0100);
   cover property (instr_exc_squash);
   cover property ($rose(checkstop));
endmodule
`default_nettype wire

// ===== bench/remc_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
module remc_sys_model (
   input wire logic pclk, // core clock
   input wire logic go_rst, // bench asks for a reset
   input wire logic go_berr, // bench asks for a bus error
   output logic sys_reset_pin, // system reset line
   output logic bus_err_pin // memory error line
);
   logic [2:0] rst_q = 3'h0;
   logic [2:0] err_q = 3'h0;
   // six cycles so the three-stage filter sees a settled level
   always_ff @(posedge pclk) begin
      if (go_rst) begin
         rst_q <= 3'h6;
      end else if (rst_q != 3'h0) begin
         rst_q <= rst_q - 3'h1;
      end
   end
   always_ff @(posedge pclk) begin
      if (go_berr) begin
         err_q <= 3'h6;
      end else if (err_q != 3'h0) begin
         err_q <= err_q - 3'h1;
      end
   end
   assign sys_reset_pin = (rst_q != 3'h0);
   assign bus_err_pin = (err_q != 3'h0);
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import remc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, fetch_vector, q;
   logic pready, pslverr, fetch_redirect, sync_full, sync_next, instr_exc_squash, halt, checkstop, e;
   logic go_rst = 1'b0;
   logic go_berr = 1'b0;
   logic sys_reset_pin, bus_err_pin;
   logic nonexist_addr = 1'b0;
   logic ctx_sync_ok = 1'b1;
   logic [31:0] next_pc = 32'h0000_1234;
   logic [31:0] exec_pc = 32'h0000_5678;
   remc_loss_t loss = '0;
   int mismatches = 0;
   int n_checks = 0;

   remc_top u_dut (.*);
   remc_sys_model u_sys (.*);

   initial begin
      forever #50 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one idle cycle after each transfer keeps psel from being assigned twice in a step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, q, x);
   endtask

   task automatic fire(input logic r, input logic b);
      go_rst <= r;
      go_berr <= b;
      @(posedge pclk);
      go_rst <= 1'b0;
      go_berr <= 1'b0;
   endtask

   task automatic entry(input logic [31:0] vec, input logic full, input logic sq);
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (fetch_redirect !== 1'b1 && n < 20);
      chk("redirect", {31'h0, fetch_redirect}, 32'h0000_0001);
      chk("vector", fetch_vector, vec);
      chk("sync", {29'h0, sync_full, sync_next, instr_exc_squash}, {29'h0, full, !full, sq});
      @(posedge pclk);
   endtask

   task automatic t_init;
      rd("msw", REMC_OFF_MSW, REMC_MSW_RST);
      rd("status", REMC_OFF_STS, 32'h0000_0001);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk("unmapped", {q[30:0], e}, 32'h0000_0001);
      wr(REMC_OFF_MSW, 32'hFFFF_FFFF);
      rd("msw", REMC_OFF_MSW, 32'h0005_FF73);
   endtask

   task automatic t_sysreset;
      fire(1'b1, 1'b0);
      entry(32'hFFF0_0100, 1'b1, 1'b0);
      rd("msw", REMC_OFF_MSW, 32'h0001_1041);
      rd("sra", REMC_OFF_SRA, 32'h0000_1234);
      rd("srs", REMC_OFF_SRS, 32'h0000_FF73);
      rd("status", REMC_OFF_STS, 32'h0000_0013);
      wr(REMC_OFF_STS, 32'h0000_0003);
      rd("status", REMC_OFF_STS, 32'h0000_0010);
   endtask

   task automatic t_mcheck;
      wr(REMC_OFF_MSW, 32'h0000_1002);
      fire(1'b0, 1'b1);
      entry(32'h0000_0200, 1'b1, 1'b1);
      rd("msw", REMC_OFF_MSW, 32'h0000_0000);
      rd("sra", REMC_OFF_SRA, 32'h0000_5678);
      rd("srs", REMC_OFF_SRS, 32'h0000_1002);
      rd("status", REMC_OFF_STS, 32'h0000_0018);
   endtask

   // machine-check enable is still clear from the last entry
   task automatic t_cstop;
      int n;
      nonexist_addr <= 1'b1;
      @(posedge pclk);
      nonexist_addr <= 1'b0;
      n = 0;
      while (checkstop !== 1'b1 && n < 10) begin
         @(negedge pclk);
         n++;
      end
      @(posedge pclk);
      chk("stop", {30'h0, halt, checkstop}, 32'h0000_0003);
      wr(REMC_OFF_MSW, 32'h0000_1000);
      rd("msw", REMC_OFF_MSW, 32'h0000_0000);
      rd("status", REMC_OFF_STS, 32'h0000_001C);
      fire(1'b1, 1'b0);
      entry(32'h0000_0100, 1'b1, 1'b0);
      chk("stop", {30'h0, halt, checkstop}, 32'h0000_0000);
   endtask

   task automatic t_unrec;
      for (int i = 0; i < 4; i++) begin
         wr(REMC_OFF_MSW, 32'h0000_1002);
         loss <= remc_loss_t'(4'h1 << i);
         fire(1'b1, 1'b0);
         entry(32'h0000_0100, 1'b0, 1'b0);
         loss <= '0;
         rd("srs", REMC_OFF_SRS, 32'h0000_1000);
      end
      ctx_sync_ok <= 1'b0;
      wr(REMC_OFF_MSW, 32'h0000_1002);
      fire(1'b0, 1'b1);
      entry(32'h0000_0200, 1'b0, 1'b1);
      ctx_sync_ok <= 1'b1;
      rd("srs", REMC_OFF_SRS, 32'h0000_1000);
   endtask

   task automatic t_prio;
      wr(REMC_OFF_MSW, 32'h0000_1000);
      fire(1'b1, 1'b1);
      entry(32'h0000_0100, 1'b1, 1'b0);
      entry(32'h0000_0200, 1'b1, 1'b1);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_init();
      t_sysreset();
      t_mcheck();
      t_cstop();
      t_unrec();
      t_prio();
      close_out();
   end

   initial begin
      repeat (5000) @(posedge pclk);
      mismatches++;
      close_out();
   end
endmodule
bind remc_top remc_assertions u_chk (.*);
`default_nettype wire
